// ---- design/phi_regs.svh ----
// Constants for the pipeline hazard interlock: stage timing, register fields.
// Assumes inclusion by the package and the design modules only.
// How it works
// RQ1 - Five stages IF ID EX MEM WB, one clock each unless a hazard stalls.
// RQ2 - Four-byte branch target at address bit1 set, bit0 clear, fetches twice.
// RQ3 - Branch causing misaligned-target double fetch takes four execution clocks in total.
// RQ4 - Two-byte targets or word-aligned four-byte targets have no double fetch.
// RQ5 - Load data read in MEM is written to its register in WB.
// RQ6 - Instruction right after a load using its register holds in ID.
// RQ7 - Load data from MEM forwards to the next instruction's ID same cycle.
// RQ8 - Load with immediately following consumer takes two execution clocks.
// RQ9 - No load-use stall when consumer sits two or more instructions later.
// RQ10 - Halfword multiply writes in WB; immediate consumer is delayed in ID.
// RQ11 - Multiply result forwards from second execute stage to next ID.
// RQ12 - No multiply-use stall when consumer sits two or more later.
// RQ13 - Saved-PC read right after its system write waits in ID.
// RQ14 - That system-register write takes three execution clocks.
// RQ15 - No stall when the saved-PC read is three or more later.
// RQ16 - Fetch and data access use separate paths, never arbitrating.
// RQ17 - ALU results forward from EX to the next instruction's ID.
// RQ18 - Jumps resolve in ID; sequential next fetch discarded, target fetched next.
// RQ19 - Stall only when an in-flight producer destination matches an ID source.
// RQ20 - During an interlock IF holds its instruction and idles flow downstream.
`ifndef PHI_REGS_SVH
`define PHI_REGS_SVH
`define PHI_REG_BITS 5
`define PHI_INSN_BITS 32
`define PHI_ADDR_BITS 32
`define PHI_R0 5'h00
`define PHI_LOAD_STALL 2'h1
`define PHI_MUL_STALL 2'h1
`define PHI_SPC_STALL 2'h2
`define PHI_ADDR_INC2 32'h0000_0002
`define PHI_ADDR_INC4 32'h0000_0004
`define PHI_NOP_INSN 32'h0000_0000
`endif

// ---- design/phi_pkg.sv ----
// Types shared by the pipeline hazard interlock modules.
// Assumes phi_regs.svh is on the include path.
`include "phi_regs.svh"
package phi_pkg;
   // Operation class decoded by the core's decoder
   typedef enum logic [2:0] {
      phi_op_alu = 3'h0,
      phi_op_load = 3'h1,
      phi_op_mul = 3'h2,
      phi_op_sys_wr = 3'h3,
      phi_op_sys_rd = 3'h4,
      phi_op_jump = 3'h5,
      phi_op_nop = 3'h6
   } phi_op_type;
   // Which saved-PC register a system access names
   typedef enum logic [1:0] {
      phi_spc_none = 2'h0,
      phi_spc_interrupt_saved_pc = 2'h1,
      phi_spc_fatal_exception_saved_pc = 2'h2
   } phi_spc_type;
   // Decoded facts about the instruction in ID
   typedef struct packed {
      logic valid;
      phi_op_type op;
      logic [4:0] dst;
      logic [4:0] src_a;
      logic [4:0] src_b;
      phi_spc_type spc;
      logic [31:0] target;
   } phi_dec_type;
   // One in-flight stage record
   typedef struct packed {
      logic valid;
      phi_op_type op;
      logic [4:0] dst;
      phi_spc_type spc;
   } phi_stage_type;
   // Forwarding selects for one operand
   typedef enum logic [3:0] {
      phi_fwd_file = 4'b0001,
      phi_fwd_ex = 4'b0010,
      phi_fwd_mem = 4'b0100,
      phi_fwd_second_execute_stage = 4'b1000
   } phi_fwd_type;
endpackage : phi_pkg

// ---- design/phi_fetch.sv ----
// Fetch unit: sequential fetch, redirect and misaligned-target double fetch.
// Assumes an instruction memory that answers each word fetch within the cycle
// that presents its address, so a word is taken at the edge that ends it.
`timescale 1ns/100ps
`default_nettype none
`include "phi_regs.svh"
module phi_fetch
   import phi_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Control from the interlock
   input wire logic hold,
   input wire logic redirect,
   input wire logic [31:0] redirect_addr,
   input wire logic target_is_long,
   // Instruction memory path
   output logic [31:0] imem_addr,
   output logic imem_req,
   input wire logic [31:0] imem_data,
   // Towards decode
   output logic [31:0] fetch_insn,
   output logic fetch_valid,
   output logic fetch_busy
);
   // Fetch states, one-hot
   typedef enum logic [2:0] {
      phi_fs_seq = 3'b001,
      phi_fs_first_misaligned_fetch = 3'b010,
      phi_fs_second_misaligned_fetch = 3'b100
   } phi_fstate_type;

   phi_fstate_type state;
   logic [15:0] low_half;
   logic misaligned;

   // A long target sitting at bit1 set, bit0 clear straddles two words
   assign misaligned = redirect && target_is_long && redirect_addr[1] && !redirect_addr[0]; // RQ2 RQ4

   // ----------------------------------------
   // Fetch sequencing
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= phi_fs_seq;
         imem_addr <= 32'h0000_0000;
         imem_req <= 1'b0;
         fetch_valid <= 1'b0;
         fetch_insn <= `PHI_NOP_INSN;
         low_half <= 16'h0000;
      end else begin
         imem_req <= 1'b1; // RQ16
         case (state)
            phi_fs_seq: begin
               if (redirect) begin
                  // Sequential word already fetched is dropped
                  fetch_valid <= 1'b0; // RQ18
                  imem_addr <= redirect_addr;
                  state <= misaligned ? phi_fs_first_misaligned_fetch : phi_fs_seq; // RQ2
               end else if (!hold && imem_req) begin
                  // No word is taken before the first request stands
                  fetch_insn <= imem_data;
                  fetch_valid <= 1'b1;
                  imem_addr <= imem_addr + `PHI_ADDR_INC4;
               end
               // On hold the fetched word stays put
            end
            phi_fs_first_misaligned_fetch: begin
               low_half <= imem_data[31:16]; // RQ2
               imem_addr <= imem_addr + `PHI_ADDR_INC2;
               fetch_valid <= 1'b0;
               state <= phi_fs_second_misaligned_fetch;
            end
            phi_fs_second_misaligned_fetch: begin
               fetch_insn <= {imem_data[15:0], low_half}; // RQ2 RQ3
               fetch_valid <= 1'b1;
               imem_addr <= imem_addr + `PHI_ADDR_INC4;
               state <= phi_fs_seq;
            end
            default: begin
               state <= phi_fs_seq;
            end
         endcase
      end
   end

   // Busy while the two-cycle assembly runs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fetch_busy <= 1'b0;
      end else begin
         fetch_busy <= misaligned || (state == phi_fs_first_misaligned_fetch);
      end
   end
endmodule : phi_fetch
`default_nettype wire

// ---- design/phi_interlock.sv ----
// Hazard detection, interlock and forwarding control for a five-stage pipe.
// Assumes the decoder supplies the ID instruction's facts each cycle and that
// the datapath applies the forwarding selects to its operand muxes.
`timescale 1ns/100ps
`default_nettype none
`include "phi_regs.svh"
module phi_interlock
   import phi_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Decoded instruction in ID
   input wire phi_dec_type id_dec,
   input wire logic target_is_long,
   // Instruction memory path
   output logic [31:0] imem_addr,
   output logic imem_req,
   input wire logic [31:0] imem_data,
   // Data memory path, independent of fetch
   input wire logic dmem_ready,
   // Towards datapath
   output logic [31:0] id_insn,
   output logic id_insn_valid,
   output logic id_stall,
   output logic issue_bubble,
   output phi_fwd_type fwd_a,
   output phi_fwd_type fwd_b,
   output logic wb_load_write,
   output logic [4:0] wb_dst,
   output logic wb_write
);
   // ----------------------------------------
   // In-flight stage records
   // ----------------------------------------
   phi_stage_type ex_stage;
   phi_stage_type mem_stage;
   logic [31:0] fetch_insn;
   logic fetch_valid;
   logic fetch_busy;
   logic redirect;
   logic hazard;
   logic spc_wait;
   logic [1:0] spc_count;
   logic issue;
   logic load_hit;
   logic mul_hit;
   logic spc_hit;
   phi_fwd_type next_fwd_a;
   phi_fwd_type next_fwd_b;

   // Producer of a general register, r0 never carries a dependency
   function automatic logic reg_hit(input phi_stage_type s, input logic [4:0] r);
      reg_hit = s.valid && (s.dst == r) && (r != `PHI_R0); // RQ19
   endfunction : reg_hit

   // Load and multiply both deliver one stage late: only the immediate
   // consumer, which sees the producer in EX, must wait one cycle.
   assign load_hit = id_dec.valid && ex_stage.op == phi_op_load
      && (reg_hit(ex_stage, id_dec.src_a) || reg_hit(ex_stage, id_dec.src_b)); // RQ6 RQ9 RQ19
   assign mul_hit = id_dec.valid && ex_stage.op == phi_op_mul
      && (reg_hit(ex_stage, id_dec.src_a) || reg_hit(ex_stage, id_dec.src_b)); // RQ10 RQ12 RQ19
   // Saved-PC write completes late, so a direct follower reading that saved PC waits two cycles
   assign spc_hit = id_dec.valid && id_dec.op == phi_op_sys_rd && id_dec.spc != phi_spc_none
      && ex_stage.valid && ex_stage.op == phi_op_sys_wr && ex_stage.spc == id_dec.spc; // RQ13 RQ15 RQ19
   assign spc_wait = spc_count != 2'h0;
   assign hazard = load_hit || mul_hit || spc_hit || spc_wait;
   assign redirect = id_dec.valid && id_dec.op == phi_op_jump && !hazard && fetch_valid; // RQ18
   assign issue = fetch_valid && !hazard && !fetch_busy;

   // ----------------------------------------
   // Fetch unit
   // ----------------------------------------
   phi_fetch u_fetch (
      .clk_sys(clk_sys),
      .srst(srst),
      .hold(hazard),
      .redirect(redirect),
      .redirect_addr(id_dec.target),
      .target_is_long(target_is_long),
      .imem_addr(imem_addr),
      .imem_req(imem_req),
      .imem_data(imem_data),
      .fetch_insn(fetch_insn),
      .fetch_valid(fetch_valid),
      .fetch_busy(fetch_busy)
   );

   // Saved-PC wait counter: stall of two cycles gives the write three clocks
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         spc_count <= 2'h0;
      end else if (spc_hit && !spc_wait) begin
         spc_count <= `PHI_SPC_STALL - 2'h1; // RQ14
      end else if (spc_wait) begin
         spc_count <= spc_count - 2'h1;
      end
   end

   // ----------------------------------------
   // Stage advance; a bubble enters EX while ID waits
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ex_stage <= '0;
         mem_stage <= '0;
      end else begin
         // Memory side never waits on fetch
         if (dmem_ready) begin // RQ16
            mem_stage <= ex_stage; // RQ1
            if (hazard || !id_dec.valid || id_dec.op == phi_op_jump) begin
               ex_stage <= '0; // RQ20
            end else begin
               ex_stage <= '{valid: 1'b1, op: id_dec.op, dst: id_dec.dst, spc: id_dec.spc};
            end
         end
      end
   end

   // Forwarding select for one source: nearest producer wins
   function automatic phi_fwd_type pick(input logic [4:0] r);
      if (reg_hit(ex_stage, r) && ex_stage.op == phi_op_alu) begin
         pick = phi_fwd_ex; // RQ17
      end else if (reg_hit(mem_stage, r) && mem_stage.op == phi_op_load) begin
         pick = phi_fwd_mem; // RQ7
      end else if (reg_hit(mem_stage, r) && mem_stage.op == phi_op_mul) begin
         pick = phi_fwd_second_execute_stage; // RQ11
      end else if (reg_hit(mem_stage, r) && mem_stage.op == phi_op_alu) begin
         pick = phi_fwd_mem;
      end else begin
         pick = phi_fwd_file;
      end
   endfunction : pick

   always_comb begin
      next_fwd_a = pick(id_dec.src_a);
      next_fwd_b = pick(id_dec.src_b);
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fwd_a <= phi_fwd_file;
         fwd_b <= phi_fwd_file;
         id_stall <= 1'b0;
         issue_bubble <= 1'b0;
         id_insn <= `PHI_NOP_INSN;
         id_insn_valid <= 1'b0;
      end else begin
         fwd_a <= next_fwd_a;
         fwd_b <= next_fwd_b;
         id_stall <= hazard; // RQ6 RQ8 RQ10 RQ13
         issue_bubble <= hazard || fetch_busy; // RQ3 RQ20
         id_insn <= fetch_insn;
         id_insn_valid <= issue;
      end
   end

   // Writeback strobes; load data lands in WB
   // Strobes fire only on the edge a record leaves MEM: a frozen data path
   // would otherwise write the same register once per waiting cycle.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_load_write <= 1'b0;
         wb_dst <= `PHI_R0;
         wb_write <= 1'b0;
      end else begin
         wb_load_write <= dmem_ready && mem_stage.valid && mem_stage.op == phi_op_load; // RQ5
         wb_dst <= mem_stage.dst;
         wb_write <= dmem_ready && mem_stage.valid && (mem_stage.op == phi_op_load
            || mem_stage.op == phi_op_mul || mem_stage.op == phi_op_alu); // RQ10
      end
   end
endmodule : phi_interlock
`default_nettype wire

// ---- testbench/phi_interlock_sva.sv ----
// Checker for the hazard interlock: stall counts and forwarding selects.
// Assumes it sees only the top module's ports, attached by bind.
`timescale 1ns/100ps
`default_nettype none
module phi_interlock_chk
   import phi_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Watched ports
   input wire phi_dec_type id_dec,
   input wire logic dmem_ready,
   input wire logic id_stall,
   input wire logic issue_bubble,
   input wire logic id_insn_valid,
   input wire phi_fwd_type fwd_a,
   input wire phi_fwd_type fwd_b,
   input wire logic wb_load_write,
   input wire logic wb_write
);
   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Producer of op o, then an ALU consumer of its register; a consumer
   // held in ID by a stall is the same instruction, not a new one
   sequence dep(phi_op_type o);
      dmem_ready && id_dec.valid && id_dec.op == o && id_dec.dst != 5'h00
      ##1 dmem_ready && id_dec.valid && id_dec.op == phi_op_alu && !id_stall
      && id_dec.src_a == $past(id_dec.dst);
   endsequence
   // Saved-PC write, then a read of the same register
   sequence spc_dep;
      dmem_ready && id_dec.valid && id_dec.op == phi_op_sys_wr
      && id_dec.spc != phi_spc_none
      ##1 dmem_ready && id_dec.valid && id_dec.op == phi_op_sys_rd
      && id_dec.spc == $past(id_dec.spc);
   endsequence
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   chk_load_one_stall: assert property (dep(phi_op_load) |=> id_stall ##1 !id_stall)
      else $error("load-use stall length wrong");
   chk_load_mem_fwd: assert property (dep(phi_op_load) |=> ##1 fwd_a == phi_fwd_mem)
      else $error("load data not forwarded from MEM");
   chk_mul_one_stall: assert property (dep(phi_op_mul) |=> id_stall ##1 !id_stall)
      else $error("multiply-use stall length wrong");
   chk_mul_ex2_fwd: assert property (dep(phi_op_mul) |=> ##1 fwd_a == phi_fwd_second_execute_stage)
      else $error("multiply result not forwarded");
   chk_alu_ex_fwd: assert property (dep(phi_op_alu) |=> !id_stall && fwd_a == phi_fwd_ex)
      else $error("ALU result not forwarded without stall");
   chk_spc_two_stall: assert property (spc_dep |=> id_stall [*2] ##1 !id_stall)
      else $error("saved-PC stall length wrong");
   chk_idle_no_stall: assert property (!id_dec.valid |=> !id_stall)
      else $error("stall without an instruction in ID");
   chk_fwd_one_hot: assert property ($onehot(fwd_a) && $onehot(fwd_b))
      else $error("forwarding select not one-hot");
   chk_stall_idles_issue: assert property (id_stall |-> issue_bubble && !id_insn_valid)
      else $error("instruction issued while ID stalled");
   chk_load_wb_write: assert property (wb_load_write |-> wb_write)
      else $error("load writeback without register write");
endmodule : phi_interlock_chk
bind phi_interlock phi_interlock_chk u_chk (.clk_sys(clk_sys), .srst(srst), .id_dec(id_dec),
   .dmem_ready(dmem_ready), .id_stall(id_stall), .issue_bubble(issue_bubble),
   .id_insn_valid(id_insn_valid), .fwd_a(fwd_a), .fwd_b(fwd_b),
   .wb_load_write(wb_load_write), .wb_write(wb_write));
`default_nettype wire

// ---- testbench/phi_rom_model.sv ----
// Instruction ROM model answering one word fetch a cycle.
// Assumes the design holds the byte address on imem_addr.
`timescale 1ns/100ps
`default_nettype none
module phi_rom_model
   import phi_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Fetch path
   input wire logic [31:0] imem_addr,
   input wire logic imem_req,
   output var logic [31:0] imem_data
);
   // Content follows the word index and answers in the cycle the address
   // stands; an idle bus shows the inverse pattern so a stray read is visible
   always_comb begin
      if (imem_req) begin
         imem_data = {~imem_addr[17:2], imem_addr[17:2]};
      end else begin
         imem_data = {imem_addr[17:2], ~imem_addr[17:2]};
      end
   end
endmodule : phi_rom_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the interlock: stalls, forwarding, redirects.
// Assumes the package, checker and ROM model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench
   import phi_pkg::*;
;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   phi_dec_type id_dec = '0;
   logic target_is_long = 1'b0;
   logic dmem_ready = 1'b1;
   logic [31:0] imem_addr, imem_data, id_insn;
   logic imem_req, id_insn_valid, id_stall, issue_bubble, wb_load_write, wb_write;
   logic [4:0] wb_dst;
   logic [4:0] last_wb = 5'h00;
   phi_fwd_type fwd_a, fwd_b;
   phi_op_type ops [3] = '{phi_op_alu, phi_op_load, phi_op_mul};
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 32'h40f2152b;
   phi_interlock DUT (.clk_sys(clk_sys), .srst(srst), .id_dec(id_dec),
      .target_is_long(target_is_long), .imem_addr(imem_addr), .imem_req(imem_req),
      .imem_data(imem_data), .dmem_ready(dmem_ready), .id_insn(id_insn),
      .id_insn_valid(id_insn_valid), .id_stall(id_stall), .issue_bubble(issue_bubble),
      .fwd_a(fwd_a), .fwd_b(fwd_b), .wb_load_write(wb_load_write), .wb_dst(wb_dst),
      .wb_write(wb_write));
   phi_rom_model rom (.clk_sys(clk_sys), .imem_addr(imem_addr), .imem_req(imem_req),
      .imem_data(imem_data));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial forever #2.5 clk_sys = ~clk_sys;
   // Last load destination seen leaving WB
   always @(posedge clk_sys) if (wb_load_write === 1'b1) last_wb <= wb_dst;
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Inputs move 1 ns after the edge so the sampling edge never races them
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   function automatic phi_dec_type mk(phi_op_type o, logic [4:0] d, logic [4:0] a, phi_spc_type s);
      mk = '{1'b1, o, d, a, 5'h00, s, 32'h0};
   endfunction : mk
   // Idle ID while the data path stutters, then drain
   task automatic flush;
      id_dec = '0;
      repeat (3) begin
         dmem_ready = 1'($random(seed));
         tick(1);
      end
      dmem_ready = 1'b1;
      tick(4);
   endtask : flush
   // Producer, fillers, then a consumer held in ID while it is stalled
   task automatic dep(input phi_dec_type p, input int gap, input phi_dec_type c,
                      input int n_exp, input logic [3:0] f_exp);
      int n;
      n = 0;
      id_dec = p;
      tick(1);
      repeat (gap) begin
         id_dec = mk(phi_op_alu, 5'h1d, 5'h1e, phi_spc_none);
         tick(1);
      end
      id_dec = c;
      tick(1);
      while (id_stall === 1'b1 && n < 4) begin
         chk("issue_bubble", issue_bubble, 1'b1);
         chk("id_insn_valid", id_insn_valid, 1'b0);
         n++;
         tick(1);
      end
      chk("stall_cycles", n, n_exp);
      if (f_exp != 4'h0) chk("fwd_a", fwd_a, f_exp);
      chk("fwd_b", fwd_b, phi_fwd_file);
      flush();
   endtask : dep
   // Jump, then count cycles until the target reaches ID
   task automatic jump(input logic [31:0] t, input logic lng, output int lat);
      logic [31:0] w0, w1, exp;
      w0 = {~t[17:2], t[17:2]};
      w1 = {~t[17:2] - 16'h0001, t[17:2] + 16'h0001};
      exp = (lng && t[1]) ? {w1[15:0], w0[31:16]} : w0;
      lat = 0;
      target_is_long = lng;
      id_dec = '{1'b1, phi_op_jump, 5'h00, 5'h00, 5'h00, phi_spc_none, t};
      tick(1);
      id_dec = '0;
      while (id_insn !== exp && lat < 12) begin
         lat++;
         tick(1);
      end
      chk("id_insn", id_insn, exp);
      flush();
   endtask : jump
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      int la, lm, ls, g;
      phi_op_type o;
      logic [4:0] d;
      tick(10);
      chk("rst_fwd_a", fwd_a, phi_fwd_file);
      srst = 1'b0;
      tick(4);
      chk("imem_req", imem_req, 1'b1);
      dep(mk(phi_op_load, 5'h06, 5'h02, phi_spc_none), 0,
          mk(phi_op_alu, 5'h07, 5'h06, phi_spc_none), 1, phi_fwd_mem);
      chk("wb_dst", last_wb, 5'h06);
      dep(mk(phi_op_load, 5'h00, 5'h02, phi_spc_none), 0,
          mk(phi_op_alu, 5'h07, 5'h00, phi_spc_none), 0, 4'h0);
      dep(mk(phi_op_load, 5'h06, 5'h02, phi_spc_none), 0,
          mk(phi_op_alu, 5'h07, 5'h08, phi_spc_none), 0, 4'h0);
      for (int s = 1; s < 3; s++) begin
         for (g = 0; g < 3; g += 2) begin
            dep(mk(phi_op_sys_wr, 5'h00, 5'h03, phi_spc_type'(s)), g,
                mk(phi_op_sys_rd, 5'h04, 5'h00, phi_spc_type'(s)), g == 0 ? 2 : 0, 4'h0);
         end
      end
      // Every producer kind at both gaps, then random registers and gaps
      for (int i = 0; i < 16; i++) begin
         o = i < 6 ? ops[i % 3] : ops[{$random(seed)} % 3];
         g = i < 6 ? i / 3 : {$random(seed)} % 2;
         d = i < 6 ? 5'h06 : 5'(1 + {$random(seed)} % 28);
         dep(mk(o, d, 5'h02, phi_spc_none), g, mk(phi_op_alu, 5'h07, d, phi_spc_none),
             (o != phi_op_alu && g == 0) ? 1 : 0,
             g != 0 ? 4'h0 : o == phi_op_load ? phi_fwd_mem :
             o == phi_op_mul ? phi_fwd_second_execute_stage : phi_fwd_ex);
      end
      jump(32'h0000_0100, 1'b1, la);
      jump(32'h0000_0102, 1'b1, lm);
      jump(32'h0000_0200, 1'b0, ls);
      chk("misaligned_latency", lm, la + 1);
      chk("short_latency", ls, la);
      print_verdict();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      fail_count++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
